// ==== verilog/osc_control_regs.svh ====
/*
 * Register map, field positions, reset values and source codes for the
 * oscillator switch and doze control block.
 * Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
 */
// Summary of operation
// - Current-source field, read-only, reports running clock source; code 110 reserved.
// - Next-source field is writable, same codes; reserved code must not be chosen.
// - Reset loads the next-source field from the boot source configuration.
// - With monitor configuration set, selection lock set-only and freezes source selection.
// - With monitor configuration clear, selection lock still sets and stays set but does not freeze source selection.
// - Pin map lock changes only after unlock; one-way configuration forbids clearing.
// - PLL lock flag is one when PLL locked, zero otherwise.
// - PLL lock flag forced zero during switches and for non-PLL sources.
// - Clock fail flag set by the monitor; software may only clear it.
// - Primary sleep enable keeps the primary oscillator running in sleep.
// - Secondary enable bit turns the 32 kHz secondary oscillator on or off.
// - Software sets switch request; device holds it until the switch completes.
// - Recover-on-interrupt set: an interrupt clears doze and restores ratio 1:1.
// - Doze ratio field is a power-of-two ratio, 1:1 up to 1:128.
// - Doze ratio resets to 1:1.
// - Doze enable applies the ratio; otherwise the ratio is forced 1:1.
// - Hardware clears doze enable on an interrupt while recovery is enabled.
// - Fast RC postscaler divides by 1,2,4,8,16,32,64 or 256.
// - System clock divider for USB divides by 1, 2, 4 or 8.
// - PLL enable bit turns on the 96 MHz PLL; software keeps it for USB/graphics.
// - Graphics clock select picks 96 MHz when one, 48 MHz when zero.
// - Switch request clears after a switch, a redundant request, or fail-safe switch.
// - Current-source field changes only at the end of a switch.
// - Clock fail flag clears on every valid clock switch.
`ifndef OSC_CONTROL_REGS_SVH
`define OSC_CONTROL_REGS_SVH

// Word offsets on the bus
`define OSC_CTRL_OFFSET 32'h0000_0000
`define CLK_DIV_OFFSET 32'h0000_0004
`define UNLOCK_OFFSET 32'h0000_0008

// Unlock keys, written back to back to the unlock register
`define UNLOCK_KEY1 32'h0000_0046
`define UNLOCK_KEY2 32'h0000_0057

// Oscillator control fields
`define CUR_SRC_MSB 14
`define CUR_SRC_LSB 12
`define NEXT_SRC_MSB 10
`define NEXT_SRC_LSB 8
`define SEL_LOCK_BIT 7
`define PIN_LOCK_BIT 6
`define PLL_LOCK_BIT 5
`define FAIL_FLAG_BIT 3
`define PRI_SLEEP_BIT 2
`define SEC_EN_BIT 1
`define SWITCH_REQ_BIT 0

// Clock divider fields
`define RECOVER_BIT 15
`define DOZE_MSB 14
`define DOZE_LSB 12
`define DOZE_EN_BIT 11
`define POSTSCALE_MSB 10
`define POSTSCALE_LSB 8
`define USB_DIV_MSB 7
`define USB_DIV_LSB 6
`define PLL96_EN_BIT 5
`define GFX_SEL_BIT 4

// Reset values
`define CLK_DIV_RESET 16'h0100
`define POSTSCALE_RESET 3'h1

// Clock source codes
`define SRC_FAST_RC 3'h0
`define SRC_FAST_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_PRIMARY_PLL 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_LOW_POWER_RC 3'h5
`define SRC_RESERVED 3'h6
`define SRC_FAST_RC_DIV 3'h7

`endif

// ==== verilog/osc_control_pkg.sv ====
/*
 * Types shared by the oscillator switch and doze control block.
 * Assumes the constants header is included by its users.
 */
package osc_control_pkg;

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_REQUEST,
      SW_RELEASE
   } switch_state_t;

   // Settings delivered to the clock tree
   typedef struct packed {
      logic primaryOscRun;
      logic secondaryOscEn;
      logic pll96En;
      logic graphicsSel96;
      logic [3:0] fastRcDivLog2;
      logic [1:0] sysClkDivLog2;
      logic [2:0] dozeLog2;
   } clk_tree_t;

endpackage : osc_control_pkg

// ==== verilog/osc_switch_and_doze_control.sv ====
/*
 * Oscillator control and clock divider registers behind an AHB-Lite slave,
 * the clock switch sequencer, and the doze clock enable divider.
 * Assumes the oscillator fabric answers a switch request with a level
 * acknowledge, and that pins from the analog side are asynchronous.
 */
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "osc_control_regs.svh"

module osc_switch_and_doze_control
   import osc_control_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Configuration straps, asynchronous
   input wire logic [2:0] boot_source_cfg,
   input wire logic switch_monitor_cfg,
   input wire logic one_way_pin_lock_cfg,
   // Oscillator fabric, asynchronous
   input wire logic pllLocked,
   input wire logic failDetect,
   input wire logic switchAck,
   output logic switchReq,
   output logic [2:0] switchTarget,
   // Core events, same clock
   input wire logic irqEvent,
   input wire logic sleepMode,
   // Clock tree settings
   output clk_tree_t clkTree,
   output logic pinMapLock,
   output logic cpuClkEn
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic usesPll(input logic [2:0] src);
      usesPll = (src == `SRC_FAST_RC_PLL) || (src == `SRC_PRIMARY_PLL);
   endfunction : usesPll

   function automatic logic [3:0] fastRcLog2(input logic [2:0] sel);
      // Top code skips divide by 128 and goes to 256
      fastRcLog2 = (sel == 3'h7) ? 4'h8 : {1'b0, sel};
   endfunction : fastRcLog2

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for the asynchronous inputs

   logic [2:0] bootMeta_q, bootSync_q;
   logic monMeta_q, monSync_q, oneWayMeta_q, oneWaySync_q;
   logic pllMeta_q, pllSync_q, failMeta_q, failSync_q, failSeen_q;
   logic ackMeta_q, ackSync_q;
   logic failEdge;

   always_ff @(posedge core_clk)
   begin
      bootMeta_q <= boot_source_cfg;
      bootSync_q <= bootMeta_q;
      monMeta_q <= switch_monitor_cfg;
      monSync_q <= monMeta_q;
      oneWayMeta_q <= one_way_pin_lock_cfg;
      oneWaySync_q <= oneWayMeta_q;
      pllMeta_q <= pllLocked;
      pllSync_q <= pllMeta_q;
      failMeta_q <= failDetect;
      failSync_q <= failMeta_q;
      ackMeta_q <= switchAck;
      ackSync_q <= ackMeta_q;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         failSeen_q <= 1'b0;
      else
         failSeen_q <= failSync_q;
   end

   assign failEdge = failSync_q & ~failSeen_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: writes take no wait state, reads take one

   logic wrPend_q, rdPend_q, hreadyout_q;
   logic [31:0] wrAddr_q, rdAddr_q, hrdata_q, readMux;
   logic addrPhase, wrOsc, wrDiv, wrKey;

   assign addrPhase = hsel & htrans[1] & hready;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         wrAddr_q <= 32'h0000_0000;
         rdAddr_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         wrPend_q <= addrPhase & hwrite;
         rdPend_q <= addrPhase & ~hwrite;
         if (addrPhase)
         begin
            wrAddr_q <= haddr;
            rdAddr_q <= haddr;
         end
         // Read data is taken after pending writes have landed
         hreadyout_q <= ~(addrPhase & ~hwrite);
         if (rdPend_q)
            hrdata_q <= readMux;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Unlock key sequence

   logic keyHalf_q, unlocked_q;

   assign wrKey = wrPend_q & (wrAddr_q == `UNLOCK_OFFSET);
   assign wrOsc = wrPend_q & (wrAddr_q == `OSC_CTRL_OFFSET) & unlocked_q;
   assign wrDiv = wrPend_q & (wrAddr_q == `CLK_DIV_OFFSET);

   // Unlock lasts only up to the next bus write of any kind
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         keyHalf_q <= 1'b0;
         unlocked_q <= 1'b0;
      end
      else if (wrPend_q)
      begin
         keyHalf_q <= wrKey & (hwdata == `UNLOCK_KEY1);
         unlocked_q <= wrKey & keyHalf_q & (hwdata == `UNLOCK_KEY2);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator control: software fields

   logic [2:0] nextSrc_q;
   logic selLock_q, pinLock_q, priSleep_q, secEn_q;
   logic selFrozen;

   assign selFrozen = monSync_q & selLock_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         nextSrc_q <= bootSync_q;
         selLock_q <= 1'b0;
         pinLock_q <= 1'b0;
         priSleep_q <= 1'b0;
         secEn_q <= 1'b0;
      end
      else if (wrOsc)
      begin
         // Reserved code is refused, the old choice stays
         if (!selFrozen && hwdata[`NEXT_SRC_MSB:`NEXT_SRC_LSB] != `SRC_RESERVED)
            nextSrc_q <= hwdata[`NEXT_SRC_MSB:`NEXT_SRC_LSB];
         if (hwdata[`SEL_LOCK_BIT])
            selLock_q <= 1'b1;
         if (!(oneWaySync_q && pinLock_q))
            pinLock_q <= hwdata[`PIN_LOCK_BIT];
         priSleep_q <= hwdata[`PRI_SLEEP_BIT];
         secEn_q <= hwdata[`SEC_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch sequencer

   switch_state_t swState_q;
   logic [2:0] curSrc_q, target_q;
   logic switchReqBit_q, bootPend_q, failFlag_q, pllFlag_q, switchReq_q;
   logic swWanted, reqWrite;

   assign reqWrite = wrOsc & hwdata[`SWITCH_REQ_BIT] & ~selFrozen;
   assign swWanted = switchReqBit_q | bootPend_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         swState_q <= SW_IDLE;
         curSrc_q <= `SRC_FAST_RC_DIV;
         target_q <= `SRC_FAST_RC_DIV;
         switchReqBit_q <= 1'b0;
         bootPend_q <= 1'b1;
         switchReq_q <= 1'b0;
      end
      else if (failEdge)
      begin
         // Fail-safe falls back to the fast RC and drops any request
         swState_q <= SW_IDLE;
         curSrc_q <= `SRC_FAST_RC;
         switchReqBit_q <= 1'b0;
         bootPend_q <= 1'b0;
         switchReq_q <= 1'b0;
      end
      else
      begin
         if (reqWrite)
            switchReqBit_q <= 1'b1;
         unique case (swState_q)
            SW_IDLE:
               if (swWanted && !reqWrite)
               begin
                  if (nextSrc_q == curSrc_q)
                  begin
                     switchReqBit_q <= 1'b0;
                     bootPend_q <= 1'b0;
                  end
                  else
                  begin
                     target_q <= nextSrc_q;
                     switchReq_q <= 1'b1;
                     swState_q <= SW_REQUEST;
                  end
               end
            SW_REQUEST:
               if (ackSync_q)
               begin
                  curSrc_q <= target_q;
                  // A request written in the closing cycle is kept, not lost
                  switchReqBit_q <= reqWrite;
                  bootPend_q <= 1'b0;
                  switchReq_q <= 1'b0;
                  swState_q <= SW_RELEASE;
               end
            SW_RELEASE:
               if (!ackSync_q)
                  swState_q <= SW_IDLE;
         endcase
      end
   end

   assign switchReq = switchReq_q;
   assign switchTarget = target_q;

   // Monitor sets, software clears with a zero; a set wins over a clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
         failFlag_q <= 1'b0;
      else if (failEdge)
         failFlag_q <= 1'b1;
      else if (swState_q == SW_REQUEST && ackSync_q)
         failFlag_q <= 1'b0;
      else if (wrOsc && !hwdata[`FAIL_FLAG_BIT])
         failFlag_q <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         pllFlag_q <= 1'b0;
      else
         pllFlag_q <= pllSync_q & usesPll(curSrc_q) & (swState_q == SW_IDLE)
            & ~switchReq_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock divider register

   logic recover_q, dozeEn_q, pll96_q, gfxSel_q;
   logic [2:0] doze_q, postscale_q;
   logic [1:0] usbDiv_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         recover_q <= 1'b0;
         doze_q <= 3'h0;
         postscale_q <= `POSTSCALE_RESET;
         usbDiv_q <= 2'h0;
         pll96_q <= 1'b0;
         gfxSel_q <= 1'b0;
      end
      else if (wrDiv)
      begin
         recover_q <= hwdata[`RECOVER_BIT];
         doze_q <= hwdata[`DOZE_MSB:`DOZE_LSB];
         postscale_q <= hwdata[`POSTSCALE_MSB:`POSTSCALE_LSB];
         usbDiv_q <= hwdata[`USB_DIV_MSB:`USB_DIV_LSB];
         pll96_q <= hwdata[`PLL96_EN_BIT];
         gfxSel_q <= hwdata[`GFX_SEL_BIT];
      end
   end

   // Recovery beats a simultaneous software set so no interrupt is slowed
   always_ff @(posedge core_clk)
   begin
      if (rst)
         dozeEn_q <= 1'b0;
      else if (irqEvent && recover_q)
         dozeEn_q <= 1'b0;
      else if (wrDiv)
         dozeEn_q <= hwdata[`DOZE_EN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unused bits read zero

   always_comb
   begin
      readMux = 32'h0000_0000;
      if (rdAddr_q == `OSC_CTRL_OFFSET)
      begin
         readMux[`CUR_SRC_MSB:`CUR_SRC_LSB] = curSrc_q;
         readMux[`NEXT_SRC_MSB:`NEXT_SRC_LSB] = nextSrc_q;
         readMux[`SEL_LOCK_BIT] = selLock_q;
         readMux[`PIN_LOCK_BIT] = pinLock_q;
         readMux[`PLL_LOCK_BIT] = pllFlag_q;
         readMux[`FAIL_FLAG_BIT] = failFlag_q;
         readMux[`PRI_SLEEP_BIT] = priSleep_q;
         readMux[`SEC_EN_BIT] = secEn_q;
         readMux[`SWITCH_REQ_BIT] = switchReqBit_q;
      end
      else if (rdAddr_q == `CLK_DIV_OFFSET)
      begin
         readMux[`RECOVER_BIT] = recover_q;
         readMux[`DOZE_MSB:`DOZE_LSB] = doze_q;
         readMux[`DOZE_EN_BIT] = dozeEn_q;
         readMux[`POSTSCALE_MSB:`POSTSCALE_LSB] = postscale_q;
         readMux[`USB_DIV_MSB:`USB_DIV_LSB] = usbDiv_q;
         readMux[`PLL96_EN_BIT] = pll96_q;
         readMux[`GFX_SEL_BIT] = gfxSel_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock tree settings and doze enable divider

   clk_tree_t clkTree_q;
   logic [6:0] dozeCnt_q;
   logic cpuClkEn_q;
   logic [6:0] dozeMask;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         clkTree_q <= '0;
         pinMapLock <= 1'b0;
      end
      else
      begin
         clkTree_q.primaryOscRun <= ~sleepMode | priSleep_q;
         clkTree_q.secondaryOscEn <= secEn_q;
         clkTree_q.pll96En <= pll96_q;
         clkTree_q.graphicsSel96 <= gfxSel_q;
         clkTree_q.fastRcDivLog2 <= fastRcLog2(postscale_q);
         clkTree_q.sysClkDivLog2 <= usbDiv_q;
         clkTree_q.dozeLog2 <= dozeEn_q ? doze_q : 3'h0;
         pinMapLock <= pinLock_q;
      end
   end

   assign clkTree = clkTree_q;
   assign dozeMask = 7'(({7'h00, 1'b1} << clkTree_q.dozeLog2) - 8'h01);

   // One CPU enable pulse for every 2^n core clocks
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         dozeCnt_q <= 7'h00;
         cpuClkEn_q <= 1'b0;
      end
      else
      begin
         dozeCnt_q <= (dozeCnt_q + 7'h01) & dozeMask;
         cpuClkEn_q <= ((dozeCnt_q & dozeMask) == 7'h00);
      end
   end

   assign cpuClkEn = cpuClkEn_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_next_not_reserved: assert property (nextSrc_q != `SRC_RESERVED
      || $past(rst) || $past(nextSrc_q) == `SRC_RESERVED)
      else $error("reserved next source accepted");

   a_sel_lock_sticky: assert property (selLock_q |=> selLock_q)
      else $error("selection lock cleared");

   a_pin_lock_oneway: assert property (oneWaySync_q && pinLock_q
      |=> pinLock_q)
      else $error("one-way pin map lock cleared");

   a_pll_flag_src: assert property (pllFlag_q
      |-> usesPll($past(curSrc_q)) && $past(pllSync_q))
      else $error("pll lock flag without pll source");

   a_pll_flag_switch: assert property (swState_q != SW_IDLE
      |=> !pllFlag_q)
      else $error("pll lock flag set during a switch");

   a_fail_sets_flag: assert property (failEdge |=> failFlag_q
      && curSrc_q == `SRC_FAST_RC && !switchReqBit_q)
      else $error("fail-safe switch not taken");

   a_cur_at_end: assert property (curSrc_q != $past(curSrc_q)
      |-> $past(failEdge) || ($past(swState_q) == SW_REQUEST
      && $past(ackSync_q)))
      else $error("current source changed mid switch");

   a_switch_bit_held: assert property (swState_q == SW_REQUEST
      |-> switchReqBit_q || bootPend_q)
      else $error("switch request dropped early");

   a_switch_clears_fail: assert property (swState_q == SW_REQUEST
      && ackSync_q && !failEdge |=> !failFlag_q)
      else $error("fail flag kept over switch");

   a_doze_recover: assert property (irqEvent && recover_q
      |=> !dozeEn_q ##1 clkTree_q.dozeLog2 == 3'h0)
      else $error("doze kept after interrupt");

   a_doze_ratio_off: assert property (!dozeEn_q
      |=> clkTree_q.dozeLog2 == 3'h0)
      else $error("doze ratio applied while disabled");

   a_postscale_map: assert property (postscale_q == 3'h7
      |=> clkTree_q.fastRcDivLog2 == 4'h8)
      else $error("postscale top code wrong");

endmodule : osc_switch_and_doze_control

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench for the oscillator switch and doze control block.
 * Assumes the design package and register header; the bench is the bus
 * master and plays the oscillator fabric, which echoes the switch request.
 */
`timescale 1ns/100ps
`include "osc_control_regs.svh"

module tb_top;
   import osc_control_pkg::*;
   logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r, d;
   logic [1:0] htrans;
   logic [2:0] hsize, boot_source_cfg, switchTarget;
   logic switch_monitor_cfg, one_way_pin_lock_cfg, pllLocked, failDetect;
   logic switchAck, switchReq, irqEvent, sleepMode, pinMapLock, cpuClkEn;
   clk_tree_t clkTree;
   int fails, checks, n, seed;

   assign hready = hreadyout;

   osc_switch_and_doze_control i_osc_switch_and_doze_control (
      .core_clk(core_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .boot_source_cfg(boot_source_cfg),
      .switch_monitor_cfg(switch_monitor_cfg),
      .one_way_pin_lock_cfg(one_way_pin_lock_cfg),
      .pllLocked(pllLocked),
      .failDetect(failDetect),
      .switchAck(switchAck),
      .switchReq(switchReq),
      .switchTarget(switchTarget),
      .irqEvent(irqEvent),
      .sleepMode(sleepMode),
      .clkTree(clkTree),
      .pinMapLock(pinMapLock),
      .cpuClkEn(cpuClkEn)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Fabric acknowledge follows the request a cycle late, four-phase
   always @(posedge core_clk)
      switchAck <= switchReq;

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("Counts: %0d compares, %0d mismatches", checks, fails);
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   task automatic tout;
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      stop_test();
   endtask : tout

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
            exp);
      end
   endtask : chk

   // Sampled mid-cycle so the edge's own updates never race the check
   task automatic waitRdy;
      logic rdy;
      for (int k = 0; k < 20; k++)
      begin
         @(negedge core_clk);
         rdy = hreadyout;
         r = hrdata;
         @(posedge core_clk);
         if (rdy === 1'b1)
            return;
      end
      tout();
   endtask : waitRdy

   task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
   endtask : bus

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
      input string msg);
      bus(1'b0, a, 32'h0);
      chk(r, exp, msg);
   endtask : rdc

   // Oscillator control only takes a write straight after the key pair
   task automatic uwr(input logic [15:0] v);
      bus(1'b1, `UNLOCK_OFFSET, `UNLOCK_KEY1);
      bus(1'b1, `UNLOCK_OFFSET, `UNLOCK_KEY2);
      bus(1'b1, `OSC_CTRL_OFFSET, {16'h0, v});
   endtask : uwr

   task automatic waitSw;
      for (int k = 0; k < 20; k++)
      begin
         bus(1'b0, `OSC_CTRL_OFFSET, 32'h0);
         if (r[0] === 1'b0)
            return;
      end
      tout();
   endtask : waitSw

   task automatic waitReq(input logic [2:0] t);
      for (int k = 0; k < 20 && switchReq !== 1'b1; k++)
         @(negedge core_clk);
      chk({switchReq, switchTarget}, {1'b1, t}, "switch request");
      @(posedge core_clk);
   endtask : waitReq

   task automatic cyc(input int c);
      repeat (c) @(posedge core_clk);
   endtask : cyc

   function automatic logic [11:0] treeExp(input logic [15:0] v);
      logic [3:0] rc;
      rc = (v[10:8] == 3'h7) ? 4'h8 : {1'b0, v[10:8]};
      return {v[5], v[4], rc, v[7:6], v[11] ? v[14:12] : 3'h0};
   endfunction : treeExp

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      boot_source_cfg = 3'h2;
      switch_monitor_cfg = 1'b0;
      one_way_pin_lock_cfg = 1'b1;
      pllLocked = 1'b1;
      failDetect = 1'b0;
      switchAck = 1'b0;
      irqEvent = 1'b0;
      sleepMode = 1'b1;
      fails = 0;
      checks = 0;
      seed = 32'h57b03331;
      cyc(4);
      rst <= 1'b0;
      rdc(`CLK_DIV_OFFSET, 32'h0100, "divider reset");
      waitSw();
      rdc(`OSC_CTRL_OFFSET, 32'h2200, "boot switch");
      bus(1'b1, `OSC_CTRL_OFFSET, 32'h0401);
      rdc(`OSC_CTRL_OFFSET, 32'h2200, "write without key");
      $display("Test boot done");

      // Switch to fast RC with PLL; writing one to the fail flag is void
      uwr(16'h010f);
      waitReq(3'h1);
      waitSw();
      // Lock flag returns only once the handshake has fully closed
      cyc(4);
      rdc(`OSC_CTRL_OFFSET, 32'h1126, "pll switch");
      chk(clkTree.secondaryOscEn, 1'b1, "secondary on");
      chk(clkTree.primaryOscRun, 1'b1, "primary in sleep");
      pllLocked <= 1'b0;
      cyc(4);
      rdc(`OSC_CTRL_OFFSET, 32'h1106, "pll unlocked");
      uwr(16'h0606);
      rdc(`OSC_CTRL_OFFSET, 32'h1106, "reserved code");
      uwr(16'h0102);
      rdc(`OSC_CTRL_OFFSET, 32'h1102, "primary off");
      chk(clkTree.primaryOscRun, 1'b0, "primary stops");
      sleepMode <= 1'b0;
      cyc(2);
      chk(clkTree.primaryOscRun, 1'b1, "primary awake");
      sleepMode <= 1'b1;
      uwr(16'h0103);
      waitSw();
      rdc(`OSC_CTRL_OFFSET, 32'h1102, "redundant switch");
      $display("Test switch done");

      failDetect <= 1'b1;
      cyc(6);
      failDetect <= 1'b0;
      rdc(`OSC_CTRL_OFFSET, 32'h010a, "clock failure");
      // Fail bit written as one, so only the switch may clear it
      uwr(16'h020b);
      waitReq(3'h2);
      waitSw();
      rdc(`OSC_CTRL_OFFSET, 32'h2202, "fail flag cleared");
      $display("Test failure done");

      uwr(16'h0242);
      cyc(2);
      chk(pinMapLock, 1'b1, "pin lock set");
      uwr(16'h0202);
      rdc(`OSC_CTRL_OFFSET, 32'h2242, "pin lock one way");
      uwr(16'h03c3);
      waitSw();
      rdc(`OSC_CTRL_OFFSET, 32'h33c2, "lock ignored");
      uwr(16'h0342);
      rdc(`OSC_CTRL_OFFSET, 32'h33c2, "lock set only");
      switch_monitor_cfg <= 1'b1;
      cyc(4);
      uwr(16'h0443);
      cyc(4);
      chk(switchReq, 1'b0, "locked no request");
      rdc(`OSC_CTRL_OFFSET, 32'h33c2, "locked selection");
      $display("Test locks done");

      // Corner values first, then random divider settings
      for (int i = 0; i < 12; i++)
      begin
         d = (i == 0) ? 32'hffff : (i == 1) ? 32'h0 : $random(seed);
         // Source is the PLL branch and USB is absent: any divider is legal
         bus(1'b1, `CLK_DIV_OFFSET, d);
         rdc(`CLK_DIV_OFFSET, {16'h0, d[15:4], 4'h0}, "divider");
         chk({clkTree.pll96En, clkTree.graphicsSel96, clkTree.fastRcDivLog2,
            clkTree.sysClkDivLog2, clkTree.dozeLog2}, treeExp(d[15:0]),
            "tree");
      end
      $display("Test divider done");

      bus(1'b1, `CLK_DIV_OFFSET, 32'hb800);
      cyc(4);
      n = 0;
      repeat (64)
      begin
         @(negedge core_clk);
         n += (cpuClkEn === 1'b1);
      end
      chk(n, 8, "doze pulses");
      @(posedge core_clk);
      irqEvent <= 1'b1;
      cyc(1);
      irqEvent <= 1'b0;
      rdc(`CLK_DIV_OFFSET, 32'hb000, "recover clears");
      chk(clkTree.dozeLog2, 3'h0, "ratio back to 1:1");
      bus(1'b1, `CLK_DIV_OFFSET, 32'h3800);
      irqEvent <= 1'b1;
      cyc(1);
      irqEvent <= 1'b0;
      rdc(`CLK_DIV_OFFSET, 32'h3800, "no recovery");
      chk(clkTree.dozeLog2, 3'h3, "doze kept");
      rdc(32'h10, 32'h0, "unmapped read");
      chk(hresp, 1'b0, "okay response");
      $display("Test doze done");
      stop_test();
   end
endmodule : tb_top
